// ---- bench/ebac_ctrl_props.sv ----
// Port assertions for the nonvolatile byte access controller.
`include "ebac_defines.vh"
`default_nettype none
module ebac_props (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       flashSelfprogBusy,
  input wire logic       cpuStall
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ctlWr = regWrite && regAddr == `EBAC_CONTROL;
  chk_stall_cause: assert property
    ($rose(cpuStall) |-> $past(ctlWr)) else $error("stall without cause");
  chk_stall_min: assert property
    ($rose(cpuStall) |-> cpuStall[*2]) else $error("stall too short");
  chk_stall_max: assert property
    (cpuStall[*4] |=> !cpuStall) else $error("stall too long");
  chk_rdata_idle: assert property
    (!$past(regRead) |-> regRdata == 8'h00) else $error("stray read data");
  chk_addr_high: assert property
    (regRead && regAddr == `EBAC_ADDR_HIGH |=> regRdata[7:1] == 7'h00)
    else $error("upper address bits set");
  chk_ctl_reserved: assert property
    (regRead && regAddr == `EBAC_CONTROL |=> regRdata[7:4] == 4'h0
      && !regRdata[0]) else $error("control reserved bits set");
  chk_flash_block: assert property
    (flashSelfprogBusy[*4] ##0 ctlWr && regWdata == 8'h02 |=> !cpuStall)
    else $error("write during flash programming");
  chk_arm_expire: assert property
    (ctlWr && regWdata == 8'h04 ##[5:8] ctlWr && regWdata == 8'h02
      |=> !cpuStall) else $error("write after arm expired");
endmodule // ebac_props
bind ebac_ctrl ebac_props u_props (.*);
`default_nettype wire

// ---- bench/ebac_osc_model.sv ----
// Free running calibrated oscillator that times each array write.
`default_nettype none
module ebac_osc_model (
  output var logic oscClk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    oscClk = 1'b0;
    forever #10.3 oscClk = ~oscClk;
  end
endmodule // ebac_osc_model
`default_nettype wire

// ---- bench/tb_eeprom_byte_access_ctrl.sv ----
// Register level test of the nonvolatile byte access controller.
`include "ebac_defines.vh"
`default_nettype none
module tb_eeprom_byte_access_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] CTL = `EBAC_CONTROL;
  logic       clk_sys, reset_n, regWrite, regRead, oscClk, fBusy, gie;
  logic       cpuStall, irqOut;
  logic [5:0] regAddr;
  logic [7:0] regWdata, regRdata, v;
  int         err_count = 0, checks_done = 0;
  ebac_ctrl #(.OSC_CYCLES(20)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .oscClk(oscClk),
    .flashSelfprogBusy(fBusy), .globalIrqEnable(gie),
    .cpuStall(cpuStall), .irqOut(irqOut));
  ebac_osc_model u_osc (.oscClk(oscClk));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic idle;
    int i;
    i = 0;
    rd(CTL);
    while (v[1] !== 1'b0 && i < 1000) begin
      rd(CTL);
      i++;
    end
    if (i == 1000) begin
      err_count++;
      conclude();
    end
  endtask
  initial begin
    {reset_n, regWrite, regRead, fBusy, gie, regAddr, regWdata} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(CTL);
    chk("ctl reset", 8'h00, v);
    $display("end reset");
    wr(`EBAC_ADDR_HIGH, 8'hff);
    rd(`EBAC_ADDR_HIGH);
    chk("addr high", 8'h01, v);
    wr(`EBAC_ADDR_LOW, 8'hff);
    wr(`EBAC_DATA, 8'ha5);
    wr(CTL, 8'h04);
    wr(CTL, 8'h02);
    #1 chk("wr stall", 8'h01, {7'h00, cpuStall});
    rd(CTL);
    chk("busy", 8'h02, v & 8'h02);
    wr(`EBAC_ADDR_LOW, 8'h00);
    wr(`EBAC_DATA, 8'h3c);
    wr(CTL, 8'h01);
    rd(`EBAC_DATA);
    chk("rd refused", 8'h3c, v);
    idle();
    rd(`EBAC_ADDR_LOW);
    chk("addr kept", 8'hff, v);
    wr(CTL, 8'h01);
    rd(`EBAC_DATA);
    chk("rd byte", 8'ha5, v);
    $display("end write");
    wr(CTL, 8'h04);
    repeat (4) @(posedge clk_sys);
    wr(CTL, 8'h02);
    rd(CTL);
    chk("late strobe", 8'h00, v);
    @(posedge clk_sys) fBusy <= 1'b1;
    wr(CTL, 8'h04);
    wr(CTL, 8'h02);
    rd(CTL);
    chk("flash block", 8'h00, v & 8'h02);
    @(posedge clk_sys) fBusy <= 1'b0;
    $display("end refusals");
    @(posedge clk_sys) gie <= 1'b1;
    wr(CTL, 8'h08);
    repeat (4) @(posedge clk_sys);
    #1 chk("irq ready", 8'h01, {7'h00, irqOut});
    wr(CTL, 8'h0c);
    wr(CTL, 8'h0a);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq busy", 8'h00, {7'h00, irqOut});
    idle();
    chk("irq done", 8'h01, {7'h00, irqOut});
    wr(CTL, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq masked", 8'h00, {7'h00, irqOut});
    wr(`EBAC_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq status", 8'h01, {7'h00, irqOut});
    rd(`EBAC_IRQ_STATUS);
    chk("status", 8'h01, v & 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq clear", 8'h00, {7'h00, irqOut});
    $display("end interrupt");
    conclude();
  end
endmodule // tb_eeprom_byte_access_ctrl
`default_nettype wire

// ---- include/ebac_defines.vh ----
// Constants for the nonvolatile byte access controller.
`ifndef EBAC_DEFINES_VH
`define EBAC_DEFINES_VH
`define EBAC_ADDR_LOW    6'h21
`define EBAC_ADDR_HIGH   6'h22
`define EBAC_DATA        6'h20
`define EBAC_CONTROL     6'h1f
`define EBAC_IRQ_STATUS  6'h1e
`define EBAC_IRQ_MASK    6'h1d
`define EBAC_BIT_READ    0
`define EBAC_BIT_WRITE   1
`define EBAC_BIT_ARM     2
`define EBAC_BIT_RDYIE   3
`define EBAC_ARM_CYCLES  3'h4
`define EBAC_READ_STALL  3'h4
`define EBAC_WRITE_STALL 3'h2
`define EBAC_OSC_CYCLES  27072
`endif

// ---- verilog/ebac_ctrl.v ----
// Nonvolatile byte access controller with its 512-byte storage array.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`include "ebac_defines.vh"
`default_nettype none
module ebac_ctrl #(
  parameter OSC_CYCLES = `EBAC_OSC_CYCLES,
  parameter DEPTH      = 512
) (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire [5:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  input  wire       oscClk,
  input  wire       flashSelfprogBusy,
  input  wire       globalIrqEnable,
  output reg        cpuStall,
  output reg        irqOut
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_WRITE = 2'b10;

  reg [7:0]  storeMem [0:DEPTH-1];
  reg [8:0]  nvAddr_ff;
  reg [7:0]  nvData_ff;
  reg        armBit_ff;
  reg [2:0]  armCnt_ff;
  reg        rdyIe_ff;
  reg [1:0]  state_ff;
  reg [8:0]  wrAddr_ff;
  reg [7:0]  wrData_ff;
  reg [15:0] oscCnt_ff;
  reg [2:0]  stallCnt_ff;
  reg        oscMeta_ff;
  reg        oscSync_ff;
  reg        oscPrev_ff;
  reg        flashMeta_ff;
  reg        flashSync_ff;
  reg        gieMeta_ff;
  reg        gieSync_ff;
  reg [1:0]  irqStat_ff;
  reg [1:0]  irqMask_ff;

  wire ctlWrite  = regWrite && (regAddr == `EBAC_CONTROL);
  wire busy      = (state_ff == ST_WRITE);
  wire oscEdge   = oscSync_ff && !oscPrev_ff;
  wire wrStart   = ctlWrite && regWdata[`EBAC_BIT_WRITE] && armBit_ff &&
                   !busy && !flashSync_ff;
  wire rdStart   = ctlWrite && regWdata[`EBAC_BIT_READ] && !busy;
  wire wrDone    = busy && oscEdge && (oscCnt_ff == OSC_CYCLES - 1);
  wire readySet  = wrDone;
  wire armSet    = ctlWrite && regWdata[`EBAC_BIT_ARM] &&
                   !regWdata[`EBAC_BIT_WRITE];
  wire statRead  = regRead && (regAddr == `EBAC_IRQ_STATUS);

  function [2:0] dec3;
    input [2:0] v;
    begin
      dec3 = (v == 3'h0) ? 3'h0 : v - 3'h1;
    end
  endfunction

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscMeta_ff   <= 1'b0;
      oscSync_ff   <= 1'b0;
      oscPrev_ff   <= 1'b0;
      flashMeta_ff <= 1'b0;
      flashSync_ff <= 1'b0;
      gieMeta_ff   <= 1'b0;
      gieSync_ff   <= 1'b0;
    end else begin
      oscMeta_ff   <= oscClk;
      oscSync_ff   <= oscMeta_ff;
      oscPrev_ff   <= oscSync_ff;
      flashMeta_ff <= flashSelfprogBusy;
      flashSync_ff <= flashMeta_ff;
      gieMeta_ff   <= globalIrqEnable;
      gieSync_ff   <= gieMeta_ff;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nvAddr_ff   <= 9'h000;
      nvData_ff   <= 8'h00;
      armBit_ff   <= 1'b0;
      armCnt_ff   <= 3'h0;
      rdyIe_ff    <= 1'b0;
      state_ff    <= ST_IDLE;
      wrAddr_ff   <= 9'h000;
      wrData_ff   <= 8'h00;
      oscCnt_ff   <= 16'h0000;
      stallCnt_ff <= 3'h0;
      cpuStall    <= 1'b0;
      irqStat_ff  <= 2'b00;
      irqMask_ff  <= 2'b00;
    end else begin
      if (regWrite && !busy && regAddr == `EBAC_ADDR_LOW) begin
        nvAddr_ff[7:0] <= regWdata;
      end
      if (regWrite && !busy && regAddr == `EBAC_ADDR_HIGH) begin
        nvAddr_ff[8] <= regWdata[0];
      end
      if (regWrite && regAddr == `EBAC_DATA) begin
        nvData_ff <= regWdata;
      end
      if (regWrite && regAddr == `EBAC_IRQ_MASK) begin
        irqMask_ff <= regWdata[1:0];
      end
      if (ctlWrite) begin
        rdyIe_ff <= regWdata[`EBAC_BIT_RDYIE];
      end
      if (rdStart) begin
        nvData_ff <= storeMem[nvAddr_ff];
      end
      if (armSet) begin
        armBit_ff <= 1'b1;
        armCnt_ff <= `EBAC_ARM_CYCLES;
      end else if (armCnt_ff == 3'h1 || wrStart) begin
        armBit_ff <= 1'b0;
        armCnt_ff <= 3'h0;
      end else begin
        armCnt_ff <= dec3(armCnt_ff);
      end
      if (rdStart) begin
        stallCnt_ff <= `EBAC_READ_STALL;
        cpuStall    <= 1'b1;
      end else if (wrStart) begin
        stallCnt_ff <= `EBAC_WRITE_STALL;
        cpuStall    <= 1'b1;
      end else begin
        stallCnt_ff <= dec3(stallCnt_ff);
        cpuStall    <= (stallCnt_ff > 3'h1);
      end
      case (state_ff)
        ST_IDLE: begin
          if (wrStart) begin
            wrAddr_ff <= nvAddr_ff;
            wrData_ff <= nvData_ff;
            oscCnt_ff <= 16'h0000;
            state_ff  <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (oscEdge) begin
            oscCnt_ff <= oscCnt_ff + 16'h0001;
          end
          if (wrDone) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      irqStat_ff[0] <= readySet | (irqStat_ff[0] & ~statRead);
      irqStat_ff[1] <= (wrStart | rdStart) | (irqStat_ff[1] & ~statRead);
    end
  end

  always @(posedge clk_sys) begin
    if (wrDone) begin
      storeMem[wrAddr_ff] <= wrData_ff;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
      irqOut   <= 1'b0;
    end else begin
      irqOut <= (rdyIe_ff && gieSync_ff && !busy) ||
                (|(irqStat_ff & irqMask_ff));
      if (regRead) begin
        case (regAddr)
          `EBAC_ADDR_LOW:   regRdata <= nvAddr_ff[7:0];
          `EBAC_ADDR_HIGH:  regRdata <= {7'h00, nvAddr_ff[8]};
          `EBAC_DATA:       regRdata <= nvData_ff;
          `EBAC_CONTROL:    regRdata <= {4'h0, rdyIe_ff, armBit_ff, busy, 1'b0};
          `EBAC_IRQ_STATUS: regRdata <= {6'h00, irqStat_ff};
          `EBAC_IRQ_MASK:   regRdata <= {6'h00, irqMask_ff};
          default:          regRdata <= 8'h00;
        endcase
      end else begin
        regRdata <= 8'h00;
      end
    end
  end
endmodule // ebac_ctrl
`default_nettype wire
